// ===== common/video_port_pkg.sv
// constants, types and state layout for the video port mode control block
package video_port_pkg;

    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h04;

    localparam int          DUAL_BIT          = 0;
    localparam int          OUTPUT_BIT        = 1;
    localparam int          TS_BIT            = 2;
    localparam int          RSVD_BIT          = 3;
    localparam int          PIN1_POL_BIT      = 4;
    localparam int          PIN2_POL_BIT      = 5;
    localparam int          PIN3_POL_BIT      = 6;
    localparam int          CLK2_INV_BIT      = 7;
    localparam int          HALT_BIT          = 14;
    localparam int          SWRST_BIT         = 15;
    localparam int          BLOCKED_BIT       = 3;

    localparam logic [7:0]  FIELD_RESET       = 8'h00;
    localparam logic [7:0]  FIELD_WRITE_MASK  = 8'hf7;
    localparam logic        HALT_RESET        = 1'b1;

    // control pins: bit 0 is pin one, bit 2 is pin three
    typedef logic [2:0] ctl3_t;

    typedef enum logic [1:0] {
        MODE_SINGLE_CAPTURE,
        MODE_DUAL_CAPTURE,
        MODE_DISPLAY,
        MODE_TS_CAPTURE
    } port_mode_t;

    typedef struct packed {
        logic clock2_invert;
        logic ctl_pin3_polarity;
        logic ctl_pin2_polarity;
        logic ctl_pin1_polarity;
        logic reserved;
        logic transport_stream_capture_select;
        logic output_mode_select;
        logic dual_channel_select;
    } ctl_fields_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        ctl_fields_t fields;
        logic        port_halted;
        logic        swrst;
        logic        blk_meta;
        logic        blk;
        ctl3_t       pin_meta;
        ctl3_t       pin_sync;
        ctl3_t       pin_out;
        ctl3_t       pin_oe;
        ctl3_t       ctl_to_core;
        ctl3_t       gpio_in;
        logic        field_id;
        port_mode_t  mode;
        logic        data_oe;
        logic        clk2_out;
        logic        clk2_oe;
    } state_t;

endpackage

// ===== logic/video_port_mode_control.sv
// video port mode and polarity control register with pin conditioning
//
// Contract
// (RQ1) in display mode clock2_invert set inverts the driven second port clock; capture ignores it.
// (RQ2) bit 6 makes control pin three active low when 1, except when the pin is gpio.
// (RQ3) pin three used as field id input skips its polarity bit; field_inversion alone inverts it.
// (RQ4) bit 5 makes control pin two active low when 1, except when the pin is gpio.
// (RQ5) bit 4 makes control pin one active low when 1, except when the pin is gpio.
// (RQ6) bit 3 is reserved, reads as 0 and ignores writes.
// (RQ7) bit 2 turns transport stream capture on when 1, off when 0, reset 0.
// (RQ8) bit 1 picks display when 1 and capture when 0, reset 0; display drives data and clock two.
// (RQ9) bit 0 picks dual channel when 1, reset 0, and is forced to 0 while dual channel is blocked.
// (RQ10) all three mode bits 0 gives single channel capture.
// (RQ11) transport 0, display 0, dual 1 gives dual channel capture, only while not blocked.
// (RQ12) transport 0 and display 1 gives single channel display whatever the dual bit.
// (RQ13) transport 1 gives transport stream capture whatever the other mode bits.
// (RQ14) mode and polarity fields change only while port_halted is 1; other writes are dropped. A soft reset still clears them while port_halted is 0.
// (RQ15) dual_channel_blocked is read only status, its value from chip configuration.
`timescale 1ns/10ps
`default_nettype none

module video_port_mode_control
    import video_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    // classic wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // chip configuration strap, asynchronous
    input  wire logic              dual_channel_blocked_in,
    // control pins
    input  wire ctl3_t             control_pin_in,
    output ctl3_t                  control_pin_out,
    output ctl3_t                  control_pin_oe,
    // core side of the control pins, active high
    input  wire ctl3_t             core_ctl_out,
    input  wire ctl3_t             core_ctl_oe,
    output ctl3_t                  core_ctl_in,
    // general purpose use of the control pins
    input  wire ctl3_t             gpio_select,
    input  wire ctl3_t             gpio_out,
    input  wire ctl3_t             gpio_oe,
    output ctl3_t                  gpio_in,
    // field id from pin three on the capture side
    input  wire logic              field_id_select,
    input  wire logic              field_inversion,
    output logic                   field_id_input,
    // display clock and data pin direction
    input  wire logic              display_clock_source,
    output logic                   port_clock_pin_two_out,
    output logic                   port_clock_pin_two_oe,
    output logic                   port_data_pins_oe,
    // decoded operating mode and the effective field copy
    output port_mode_t             port_mode,
    output logic                   port_halted,
    output ctl_fields_t            port_fields
);

    state_t s;
    state_t next_s;

    logic   accept;
    logic   wr_ctrl;
    ctl3_t  pol;
    ctl3_t  pol_in;
    logic   output_mode_select_now;

    function automatic port_mode_t decode_mode(input ctl_fields_t f);
        if (f.transport_stream_capture_select) begin
            decode_mode = MODE_TS_CAPTURE;                // [RQ13] [RQ7]
        end else if (f.output_mode_select) begin
            decode_mode = MODE_DISPLAY;                   // [RQ12] [RQ8]
        end else if (f.dual_channel_select) begin
            decode_mode = MODE_DUAL_CAPTURE;              // [RQ11]
        end else begin
            decode_mode = MODE_SINGLE_CAPTURE;            // [RQ10]
        end
    endfunction

    always_comb begin
        next_s   = s;
        accept   = wb_cyc_i && wb_stb_i && !s.ack;
        wr_ctrl  = accept && wb_we_i && (wb_adr_i == CTRL_OFFSET);
        pol      = {s.fields.ctl_pin3_polarity,
                    s.fields.ctl_pin2_polarity,
                    s.fields.ctl_pin1_polarity};
        // field id input takes its inversion from the capture channel
        pol_in   = {pol[2] && !field_id_select, pol[1:0]};    // [RQ3]
        output_mode_select_now = (s.mode == MODE_DISPLAY);

        // strap crosses two flops before anything reads it
        next_s.blk_meta = dual_channel_blocked_in;
        next_s.blk      = s.blk_meta;                         // [RQ15]
        next_s.pin_meta = control_pin_in;
        next_s.pin_sync = s.pin_meta;

        next_s.ack = accept;

        if (s.swrst) begin
            // soft reset lasts one cycle, then the port comes up halted
            next_s.fields      = ctl_fields_t'(FIELD_RESET);
            next_s.port_halted = HALT_RESET;
            next_s.swrst       = 1'b0;
        end else begin
            if (wr_ctrl && wb_sel_i[0] && s.port_halted) begin
                next_s.fields = ctl_fields_t'(wb_dat_i[7:0]
                                              & FIELD_WRITE_MASK);  // [RQ14] [RQ6]
            end
            if (wr_ctrl && wb_sel_i[1]) begin
                if (wb_dat_i[SWRST_BIT]) begin
                    next_s.swrst = 1'b1;
                end
                if (wb_dat_i[HALT_BIT]) begin
                    next_s.port_halted = 1'b0;
                end
            end
        end
        next_s.fields.reserved = 1'b0;                        // [RQ6]
        if (s.blk) begin
            next_s.fields.dual_channel_select = 1'b0;         // [RQ9]
        end

        next_s.rdata = 32'h0000_0000;
        if (accept && !wb_we_i) begin
            unique case (wb_adr_i)
                CTRL_OFFSET: begin
                    next_s.rdata[7:0]       = s.fields;
                    next_s.rdata[RSVD_BIT]  = 1'b0;           // [RQ6]
                    next_s.rdata[HALT_BIT]  = s.port_halted;
                    next_s.rdata[SWRST_BIT] = s.swrst;
                end
                STATUS_OFFSET: begin
                    next_s.rdata[BLOCKED_BIT] = s.blk;        // [RQ15]
                end
                default: begin
                    next_s.rdata = 32'h0000_0000;
                end
            endcase
        end

        next_s.mode = decode_mode(s.fields);

        // gpio bypasses polarity in both directions
        next_s.pin_out = (gpio_select & gpio_out)
                       | (~gpio_select & (core_ctl_out ^ pol));  // [RQ2] [RQ4] [RQ5]
        next_s.pin_oe  = (gpio_select & gpio_oe)
                       | (~gpio_select & core_ctl_oe);
        next_s.ctl_to_core = s.pin_sync ^ pol_in;             // [RQ2] [RQ4] [RQ5]
        next_s.gpio_in     = s.pin_sync;
        next_s.field_id    = s.pin_sync[2] ^ field_inversion; // [RQ3]

        // capture ignores the inversion; the clock pin is an input then
        next_s.clk2_out = display_clock_source
                        ^ (s.fields.clock2_invert && output_mode_select_now);  // [RQ1]
        next_s.clk2_oe  = output_mode_select_now;                           // [RQ8]
        next_s.data_oe  = output_mode_select_now;                           // [RQ8]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s             <= '0;
            s.port_halted <= HALT_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o               = s.rdata;
    assign wb_ack_o               = s.ack;
    assign control_pin_out        = s.pin_out;
    assign control_pin_oe         = s.pin_oe;
    assign core_ctl_in            = s.ctl_to_core;
    assign gpio_in                = s.gpio_in;
    assign field_id_input         = s.field_id;
    assign port_clock_pin_two_out = s.clk2_out;
    assign port_clock_pin_two_oe  = s.clk2_oe;
    assign port_data_pins_oe      = s.data_oe;
    assign port_mode              = s.mode;
    assign port_halted            = s.port_halted;
    assign port_fields            = s.fields;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] field_bits;
    assign field_bits = s.fields;

    sequence soft_reset_req;
        wr_ctrl && wb_sel_i[1] && wb_dat_i[SWRST_BIT] && !s.swrst;
    endsequence

    sequence soft_reset_done;
        s.swrst ##1 (!s.swrst && s.port_halted && field_bits == FIELD_RESET);
    endsequence

    sequence locked_write;
        wr_ctrl && wb_sel_i[0] && !s.port_halted && !s.swrst;
    endsequence

    clk2_invert_a: assert property ( // [RQ1]
        1'b1 |=> port_clock_pin_two_out == ($past(display_clock_source)
            ^ ($past(s.fields.clock2_invert) && $past(s.mode) == MODE_DISPLAY)))
        else $error("clock two polarity wrong");

    pin3_out_pol_a: assert property ( // [RQ2]
        !gpio_select[2] |=> control_pin_out[2] ==
            ($past(core_ctl_out[2]) ^ $past(s.fields.ctl_pin3_polarity)))
        else $error("pin three output polarity wrong");

    field_id_path_a: assert property ( // [RQ3]
        field_id_select |=> core_ctl_in[2] == $past(s.pin_sync[2])
            && field_id_input == ($past(s.pin_sync[2]) ^ $past(field_inversion)))
        else $error("field id path wrong");

    pin2_gpio_a: assert property ( // [RQ4]
        gpio_select[1] |=> control_pin_out[1] == $past(gpio_out[1])
            && control_pin_oe[1] == $past(gpio_oe[1]))
        else $error("pin two gpio altered");

    pin1_in_pol_a: assert property ( // [RQ5]
        1'b1 |=> core_ctl_in[0] ==
            ($past(s.pin_sync[0]) ^ $past(s.fields.ctl_pin1_polarity)))
        else $error("pin one input polarity wrong");

    // status bit 3 shares the position, so only control reads are held to it
    reserved_zero_a: assert property ( // [RQ6]
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000 && !s.fields.reserved
            && ($past(wb_adr_i) != CTRL_OFFSET || !wb_dat_o[RSVD_BIT]))
        else $error("reserved bits not zero");

    ts_mode_a: assert property ( // [RQ13] [RQ7]
        s.fields.transport_stream_capture_select |=> port_mode == MODE_TS_CAPTURE
            ##1 !port_data_pins_oe)
        else $error("transport capture not selected");

    display_mode_a: assert property ( // [RQ12] [RQ8]
        (!s.fields.transport_stream_capture_select && s.fields.output_mode_select)
        [*2] |=> port_mode == MODE_DISPLAY && port_data_pins_oe
            && port_clock_pin_two_oe)
        else $error("display mode not taken");

    dual_mode_a: assert property ( // [RQ11]
        (field_bits[2:0] == 3'b001) |=> port_mode == MODE_DUAL_CAPTURE)
        else $error("dual capture not taken");

    single_mode_a: assert property ( // [RQ10]
        (field_bits[2:0] == 3'b000) |=> port_mode == MODE_SINGLE_CAPTURE)
        else $error("single capture not taken");

    dual_forced_a: assert property ( // [RQ9]
        s.blk |=> !s.fields.dual_channel_select)
        else $error("dual bit not forced off");

    locked_write_a: assert property ( // [RQ14]
        locked_write |=> field_bits[7:1] == $past(field_bits[7:1]))
        else $error("write taken while running");

    soft_reset_a: assert property ( // [RQ14]
        soft_reset_req |=> soft_reset_done)
        else $error("soft reset sequence wrong");

    status_read_a: assert property ( // [RQ15]
        accept && !wb_we_i && wb_adr_i == STATUS_OFFSET |=>
            wb_ack_o && wb_dat_o == {28'h0000000, $past(s.blk), 3'b000})
        else $error("status read wrong");

endmodule

`default_nettype wire

// ===== verif/ext_video_dev.sv
// external video device model facing the three control pins
`timescale 1ns/10ps
`default_nettype none

module ext_video_dev
    import video_port_pkg::*;
(
    input  wire ctl3_t pin_out,
    input  wire ctl3_t pin_oe,
    input  wire ctl3_t drive_val,
    input  wire ctl3_t drive_en,
    output ctl3_t      pin_level
);
    // a pin nobody drives settles to the board pull-up level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i]
                         : (drive_en[i] ? drive_val[i] : 1'b1);
        end
    end
endmodule

`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the video port mode control register
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import video_port_pkg::*;

    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [ADDR_W-1:0] wb_adr_i = '0;
    logic [3:0]        wb_sel_i = 4'hf;
    logic [31:0]       wb_dat_i = '0, wb_dat_o, rd;
    logic              wb_ack_o, dual_channel_blocked_in = 1'b0;
    ctl3_t             control_pin_in, control_pin_out, control_pin_oe;
    ctl3_t             core_ctl_out = '0, core_ctl_oe = '0, core_ctl_in;
    ctl3_t             gpio_select = '0, gpio_out = '0, gpio_oe = '0;
    ctl3_t             gpio_in, drive_val = '0, drive_en = '0;
    logic              field_id_select = 1'b0, field_inversion = 1'b0;
    logic              field_id_input, display_clock_source = 1'b0;
    logic              port_clock_pin_two_out, port_clock_pin_two_oe;
    logic              port_data_pins_oe, port_halted;
    port_mode_t        port_mode, exp_mode;
    ctl_fields_t       port_fields;
    int                fail_count = 0, n_tests = 0, cycles = 0;

    video_port_mode_control i_dut (
        .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .dual_channel_blocked_in,
        .control_pin_in, .control_pin_out, .control_pin_oe, .core_ctl_out,
        .core_ctl_oe, .core_ctl_in, .gpio_select, .gpio_out, .gpio_oe,
        .gpio_in, .field_id_select, .field_inversion, .field_id_input,
        .display_clock_source, .port_clock_pin_two_out,
        .port_clock_pin_two_oe, .port_data_pins_oe, .port_mode,
        .port_halted, .port_fields
    );

    ext_video_dev i_dev (
        .pin_out(control_pin_out), .pin_oe(control_pin_oe),
        .drive_val, .drive_en, .pin_level(control_pin_in)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one classic cycle; waits for ack under a bound, never a fixed count
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, '0);
        chk(rd, exp);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(CTRL_OFFSET, 32'h0000_4000);
        chk(32'(port_mode), 32'(MODE_SINGLE_CAPTURE));
        chk(32'(port_halted), 32'h1);
        rchk(STATUS_OFFSET, '0);
        wb(1'b1, CTRL_OFFSET, 32'h0000_00ff);
        rchk(CTRL_OFFSET, 32'h0000_40f7);
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, CTRL_OFFSET, 32'(i));
            repeat (4) @(posedge clk);
            exp_mode = i[2] ? MODE_TS_CAPTURE : i[1] ? MODE_DISPLAY :
                       i[0] ? MODE_DUAL_CAPTURE : MODE_SINGLE_CAPTURE;
            chk(32'(port_mode), 32'(exp_mode));
            chk(32'(port_data_pins_oe), 32'(exp_mode == MODE_DISPLAY));
            chk(32'(port_fields), 32'(i));
        end
        display_clock_source <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, CTRL_OFFSET, i ? 32'h82 : 32'h80);
            repeat (4) @(posedge clk);
            chk(32'(port_clock_pin_two_out), 32'(i == 0));
            chk(32'(port_clock_pin_two_oe), 32'(i));
        end
        core_ctl_out <= 3'h5;
        core_ctl_oe  <= 3'h7;
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, CTRL_OFFSET, i ? 32'h70 : 32'h00);
            repeat (4) @(posedge clk);
            chk(32'(control_pin_out), i ? 32'h2 : 32'h5);
        end
        // gpio use must ignore the active-low setting just made
        gpio_select <= 3'h7;
        gpio_out    <= 3'h6;
        gpio_oe     <= 3'h3;
        repeat (4) @(posedge clk);
        chk(32'(control_pin_out), 32'h6);
        chk(32'(control_pin_oe), 32'h3);
        gpio_oe   <= '0;
        drive_en  <= 3'h7;
        drive_val <= 3'h1;
        repeat (6) @(posedge clk);
        chk(32'(gpio_in), 32'h1);
        gpio_select <= '0;
        core_ctl_oe <= '0;
        repeat (6) @(posedge clk);
        chk(32'(core_ctl_in), 32'h6);
        field_id_select <= 1'b1;
        field_inversion <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(field_id_input), 32'h1);
        chk(32'(core_ctl_in), 32'h2);
        wb(1'b1, CTRL_OFFSET, 32'h0000_4001);
        rchk(CTRL_OFFSET, 32'h0000_0001);
        chk(32'(port_halted), 32'h0);
        chk(32'(port_mode), 32'(MODE_DUAL_CAPTURE));
        wb(1'b1, CTRL_OFFSET, 32'h0000_00fe);
        rchk(CTRL_OFFSET, 32'h0000_0001);
        wb(1'b1, CTRL_OFFSET, 32'h0000_8000);
        repeat (4) @(posedge clk);
        rchk(CTRL_OFFSET, 32'h0000_4000);
        wb(1'b1, CTRL_OFFSET, 32'h0000_0001);
        dual_channel_blocked_in <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(CTRL_OFFSET, 32'h0000_4000);
        chk(32'(port_mode), 32'(MODE_SINGLE_CAPTURE));
        wb(1'b1, STATUS_OFFSET, '0);
        rchk(STATUS_OFFSET, 32'h0000_0008);
        wb(1'b1, 8'h10, 32'h0000_00ff);
        rchk(8'h10, '0);
        rchk(CTRL_OFFSET, 32'h0000_4000);
        final_report();
    end
endmodule

`default_nettype wire
